// >>> sib_pkg.sv
package sib_pkg;
	// ---------------------------------------------------------------
	// register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_MODE = 8'h00;
	localparam logic [7:0] REG_LATCH = 8'h04;
	localparam logic [7:0] REG_LATCH_EXT = 8'h08;
	localparam logic [7:0] REG_MASK = 8'h0C;
	localparam logic [7:0] REG_MASK_EXT = 8'h10;
	localparam logic [7:0] REG_MASKP = 8'h14;
	localparam logic [7:0] REG_MASKP_EXT = 8'h18;
	localparam logic [7:0] REG_ARITH_STATUS_X = 8'h1C;
	localparam logic [7:0] REG_ARITH_STATUS_Y = 8'h20;
	localparam logic [7:0] REG_EDGE = 8'h24;
	localparam logic [7:0] REG_STATUS = 8'h28;
	// ---------------------------------------------------------------
	// fields and interrupt positions
	// ---------------------------------------------------------------
	localparam int NUM_IRQ = 42;
	localparam int LOW_W = 32;
	localparam int EXT_W = 10;
	localparam int MODE_W = 16;
	localparam int MODE_NEST_BIT = 11;
	localparam int MODE_IRQEN_BIT = 12;
	localparam logic [15:0] MODE_RESET = 16'h0000;
	localparam int IRQ_RESET = 0;
	localparam int IRQ_EMU = 1;
	localparam int IRQ_TIMER = 4;
	localparam int IRQ_EXT_TOP = 10;
	localparam int IRQ_BOOT_BASE = 20;
	localparam logic [41:0] NON_MASKABLE = 42'h000_0000_0003;
	localparam logic [41:0] STATUS_PUSH = 42'h000_0000_0710;
	localparam logic [41:0] MASK_RESET = 42'h3FF_FFFF_FFFC;
	localparam logic [2:0] EDGE_RESET = 3'h0;
	// ---------------------------------------------------------------
	// timing in core clock cycles, vector spacing and states
	// ---------------------------------------------------------------
	localparam logic [2:0] BRANCH_CYCLES = 3'h4;
	localparam logic [1:0] BOOT_SETTLE = 2'h3;
	localparam int VEC_SPACING_LOG2 = 2;
	typedef enum logic [1:0] {S_RUN, S_HOLD, S_BRANCH, S_FIRST} sib_state_t;
endpackage : sib_pkg

// >>> sib_sync.sv
`timescale 1ns/1ns
module sib_sync #(
	parameter int WIDTH = 5
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} sib_sync_st_t;
	sib_sync_st_t q;
	sib_sync_st_t next_q;

	// first stage feeds only the second stage
	always_comb
	begin
		next_q.s1 = din;
		next_q.s2 = q.s1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			q <= '0;
		else
			q <= next_q;
	end

	assign dout = q.s2;
endmodule : sib_sync

// >>> sib_stack.sv
`timescale 1ns/1ns
module sib_stack #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic push,
	input wire logic pop,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] top,
	output logic empty,
	output logic full
);
	localparam int PW = $clog2(DEPTH + 1);
	if (DEPTH < 2) begin : g_chk
		$error("stack depth below two");
	end
	typedef struct packed {
		logic [PW-1:0] ptr;
		logic [WIDTH-1:0] top;
	} sib_stk_st_t;
	sib_stk_st_t q;
	sib_stk_st_t next_q;
	logic [WIDTH-1:0] mem [DEPTH];

	// top is kept in a register so readers never see the array directly
	always_comb
	begin
		next_q = q;
		if (push && !full)
		begin
			next_q.ptr = q.ptr + PW'(1);
			next_q.top = din;
		end
		else if (pop && !empty)
		begin
			next_q.ptr = q.ptr - PW'(1);
			next_q.top = (q.ptr >= PW'(2)) ? mem[q.ptr - PW'(2)] : '0;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			q <= '0;
		else
			q <= next_q;
	end

	always_ff @(posedge clk)
	begin
		if (push && !full)
			mem[q.ptr] <= din;
	end

	assign top = q.top;
	assign empty = (q.ptr == '0);
	assign full = (q.ptr == PW'(DEPTH));

	a_push_top: assert property (@(posedge clk) disable iff (rst)
		(push && !full) |=> (top == $past(din)))
		else $error("pushed word not on top");
endmodule : sib_stack

// >>> sib_branch.sv
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
// Behaviour
// - global enable gates all maskable servicing
// - three maskable external inputs, edge or level
// - pin requests synchronised, then set in latch
// - respond when running, unmasked, enabled, highest
// - call vector, four locations apart, priority order
// - drive vector, push return address
// - push status for pins and timer only
// - clear serviced latch bit on entry
// - mask pointer shows nesting, masks accordingly
// - return resumes at stacked address, pops
// - return pops status only if pushed
// - return clears completed mask pointer bit
// - masked requests stay latched; reset, emulator unmaskable
// - reset masks all but reset, emulator; boot unmasked once pins settle
// - two sync cycles, latch cycle, four branch cycles
// - internal vector fetch lasts four clocks
// - abort address stage onward, push its address
// - one instruction completes, four aborted
// - delayed branch: wait slots, push target
// - pin requests have five cycle latency
// - nested entry waits one handler instruction
// - program memory stall: push following address
// - lower bit index means higher priority
// - active handler latch bit cleared every cycle
module sib_branch #(
	parameter int ADDR_W = 24,
	parameter int PC_DEPTH = 30,
	parameter int STAT_DEPTH = 15,
	parameter logic [ADDR_W-1:0] VEC_BASE = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] ext_irq_inputs,
	input wire logic [1:0] boot_config_pins,
	input wire logic [41:0] int_irq_req,
	input wire logic core_run,
	input wire logic db_slot,
	input wire logic pm_stall,
	input wire logic rti_exec,
	input wire logic [ADDR_W-1:0] cur_pc,
	input wire logic [ADDR_W-1:0] db_target,
	input wire logic [ADDR_W-1:0] next_pc,
	output logic vec_fetch,
	output logic [ADDR_W-1:0] vec_addr,
	output logic pipe_abort,
	output logic resume_fetch,
	output logic [ADDR_W-1:0] resume_addr
);
	localparam int SW = 3 * sib_pkg::MODE_W;
	if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk
		$error("address width out of range");
	end

	typedef struct packed {
		logic [41:0] latch, mask, maskp;
		logic [15:0] mode, astx, asty;
		logic [2:0] edge_sel, ext_prev;
		logic [1:0] boot_wait;
		sib_pkg::sib_state_t st;
		logic hold_db;
		logic [2:0] cnt;
		logic [5:0] cur;
		logic vec_fetch;
		logic [ADDR_W-1:0] vec_addr;
		logic pipe_abort, resume_fetch;
		logic [ADDR_W-1:0] resume_addr;
		logic [31:0] prdata;
		logic pready, pslverr;
	} sib_st_t;
	sib_st_t q;
	sib_st_t next_q;

	// ---------------------------------------------------------------
	// pin synchronisers and stacks
	// ---------------------------------------------------------------
	logic [4:0] pins_s;
	logic [41:0] ev, elig, blk;
	logic [6:0] pick, top_act;
	logic [5:0] sel;
	logic [ADDR_W-1:0] ret, pc_top;
	logic go, pc_push, pc_pop, st_push, st_pop, pc_empty, st_empty, wr_go;
	logic [SW-1:0] st_top;
	logic [32:0] rd;

	// sync and latch stages set pin latency
	sib_sync #(.WIDTH(5)) u_sync (
		.clk(clk), .rst(rst), .din({boot_config_pins, ext_irq_inputs}), .dout(pins_s)
	);

	sib_stack #(.WIDTH(ADDR_W), .DEPTH(PC_DEPTH)) u_pc_stack (
		.clk(clk), .rst(rst), .push(pc_push), .pop(pc_pop),
		.din(ret), .top(pc_top), .empty(pc_empty), .full()
	);

	sib_stack #(.WIDTH(SW), .DEPTH(STAT_DEPTH)) u_stat_stack (
		.clk(clk), .rst(rst), .push(st_push), .pop(st_pop),
		.din({q.mode, q.astx, q.asty}), .top(st_top), .empty(st_empty), .full()
	);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// lowest index wins
	function automatic logic [6:0] first_set(input logic [41:0] v);
		logic [6:0] r;
		r = '0;
		for (int i = sib_pkg::NUM_IRQ - 1; i >= 0; i--)
		begin
			if (v[i])
				r = {1'b1, 6'(i)};
		end
		return r;
	endfunction : first_set

	function automatic logic [32:0] read_reg(input logic [7:0] a, input sib_st_t s,
		input logic pe, input logic se);
		logic [32:0] r;
		r = {1'b1, 32'h0000_0000};
		unique case (a)
			sib_pkg::REG_MODE: r[15:0] = s.mode;
			sib_pkg::REG_LATCH: r[31:0] = s.latch[31:0];
			sib_pkg::REG_LATCH_EXT: r[9:0] = s.latch[41:32];
			sib_pkg::REG_MASK: r[31:0] = s.mask[31:0];
			sib_pkg::REG_MASK_EXT: r[9:0] = s.mask[41:32];
			sib_pkg::REG_MASKP: r[31:0] = s.maskp[31:0];
			sib_pkg::REG_MASKP_EXT: r[9:0] = s.maskp[41:32];
			sib_pkg::REG_ARITH_STATUS_X: r[15:0] = s.astx;
			sib_pkg::REG_ARITH_STATUS_Y: r[15:0] = s.asty;
			sib_pkg::REG_EDGE: r[2:0] = s.edge_sel;
			sib_pkg::REG_STATUS: r[3:0] = {se, pe, s.st};
			default: r[32] = 1'b0;
		endcase
		return r;
	endfunction : read_reg

	assign wr_go = psel && penable && pwrite && q.pready;
	assign rd = read_reg(paddr, q, pc_empty, st_empty);

	// ---------------------------------------------------------------
	// request sources and eligibility
	// ---------------------------------------------------------------
	always_comb
	begin
		ev = int_irq_req;
		for (int i = 0; i < 3; i++)
		begin
			// pin request to its latch bit
			ev[sib_pkg::IRQ_EXT_TOP - i] = q.edge_sel[i] ? (pins_s[i] && !q.ext_prev[i]) : pins_s[i];
		end
		top_act = first_set(q.maskp);
		for (int b = 0; b < sib_pkg::NUM_IRQ; b++)
		begin
			// nesting decides how much is blocked
			blk[b] = top_act[6] && (!q.mode[sib_pkg::MODE_NEST_BIT] || 6'(b) >= top_act[5:0]);
			elig[b] = q.latch[b] && (sib_pkg::NON_MASKABLE[b]
				|| (q.mode[sib_pkg::MODE_IRQEN_BIT] && !q.mask[b] && !blk[b]));
		end
		pick = first_set(elig);
	end

	// ---------------------------------------------------------------
	// sequencer, register file and state update
	// ---------------------------------------------------------------
	always_comb
	begin
		next_q = q;
		next_q.pipe_abort = 1'b0;
		next_q.resume_fetch = 1'b0;
		next_q.pready = 1'b0;
		next_q.pslverr = 1'b0;
		next_q.ext_prev = pins_s[2:0];
		go = 1'b0;
		sel = q.cur;
		ret = cur_pc;
		pc_push = 1'b0;
		pc_pop = 1'b0;
		st_push = 1'b0;
		st_pop = 1'b0;
		// zero wait slave: answer in the first access cycle
		if (psel && !penable)
		begin
			next_q.pready = 1'b1;
			next_q.prdata = rd[31:0];
			next_q.pslverr = !rd[32];
		end
		if (wr_go)
		begin
			unique case (paddr)
				sib_pkg::REG_MODE: next_q.mode = pwdata[15:0];
				sib_pkg::REG_LATCH: next_q.latch[31:0] = pwdata;
				sib_pkg::REG_LATCH_EXT: next_q.latch[41:32] = pwdata[9:0];
				sib_pkg::REG_MASK: next_q.mask[31:0] = pwdata;
				sib_pkg::REG_MASK_EXT: next_q.mask[41:32] = pwdata[9:0];
				sib_pkg::REG_ARITH_STATUS_X: next_q.astx = pwdata[15:0];
				sib_pkg::REG_ARITH_STATUS_Y: next_q.asty = pwdata[15:0];
				sib_pkg::REG_EDGE: next_q.edge_sel = pwdata[2:0];
				default: next_q.prdata = q.prdata;
			endcase
		end
		// boot source unmasked once pins settle
		if (q.boot_wait != sib_pkg::BOOT_SETTLE)
		begin
			next_q.boot_wait = q.boot_wait + 2'h1;
			if (q.boot_wait == sib_pkg::BOOT_SETTLE - 2'h1)
				next_q.mask[sib_pkg::IRQ_BOOT_BASE + int'(pins_s[4:3])] = 1'b0;
		end
		unique case (q.st)
			sib_pkg::S_RUN:
			begin
				if (pick[6] && core_run)
				begin
					next_q.cur = pick[5:0];
					if (db_slot || pm_stall)
					begin
						next_q.st = sib_pkg::S_HOLD;
						next_q.hold_db = db_slot;
					end
					else
					begin
						go = 1'b1;
						sel = pick[5:0];
						ret = cur_pc;
					end
				end
				else if (rti_exec && top_act[6] && !pc_empty)
				begin
					// resume at stacked address and pop
					next_q.resume_fetch = 1'b1;
					next_q.resume_addr = pc_top;
					pc_pop = 1'b1;
					next_q.maskp[top_act[5:0]] = 1'b0;
					// restore status only if it was saved
					if (sib_pkg::STATUS_PUSH[top_act[5:0]] && !st_empty)
					begin
						st_pop = 1'b1;
						{next_q.mode, next_q.astx, next_q.asty} = st_top;
					end
				end
			end
			sib_pkg::S_HOLD:
			begin
				if (!q.hold_db)
				begin
					go = 1'b1;
					ret = next_pc;
				end
				else if (!db_slot)
				begin
					go = 1'b1;
					ret = db_target;
				end
			end
			sib_pkg::S_BRANCH:
			begin
				next_q.cnt = q.cnt - 3'h1;
				if (q.cnt == 3'h1)
				begin
					next_q.vec_fetch = 1'b0;
					next_q.st = sib_pkg::S_FIRST;
				end
			end
			sib_pkg::S_FIRST:
			begin
				// first handler instruction runs before nesting
				next_q.st = sib_pkg::S_RUN;
			end
		endcase
		if (go)
		begin
			pc_push = 1'b1;
			// status saved for pins and timer
			st_push = sib_pkg::STATUS_PUSH[sel];
			next_q.maskp[sel] = 1'b1;
			next_q.vec_fetch = 1'b1;
			next_q.vec_addr = VEC_BASE + ADDR_W'({sel, 2'b00});
			// pipeline squashed behind one completed instruction
			next_q.pipe_abort = 1'b1;
			// one vector fetch per clock from internal memory
			next_q.cnt = sib_pkg::BRANCH_CYCLES;
			next_q.st = sib_pkg::S_BRANCH;
		end
		// active handler bits kept clear; this clear beats new events
		next_q.latch = (next_q.latch | ev) & ~next_q.maskp;
		next_q.mask = next_q.mask & ~sib_pkg::NON_MASKABLE;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			q <= '0;
			q.mask <= sib_pkg::MASK_RESET;
			q.mode <= sib_pkg::MODE_RESET;
			q.edge_sel <= sib_pkg::EDGE_RESET;
			q.st <= sib_pkg::S_RUN;
		end
		else
			q <= next_q;
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign vec_fetch = q.vec_fetch;
	assign vec_addr = q.vec_addr;
	assign pipe_abort = q.pipe_abort;
	assign resume_fetch = q.resume_fetch;
	assign resume_addr = q.resume_addr;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_branch;
		q.vec_fetch [*4] ##1 !q.vec_fetch;
	endsequence
	sequence s_first;
		!q.vec_fetch ##1 (q.st == sib_pkg::S_RUN);
	endsequence

	a_branch_len: assert property ($rose(q.vec_fetch) |-> s_branch)
		else $error("vector fetch not four cycles");
	a_nest_gap: assert property ($fell(q.vec_fetch) |-> s_first)
		else $error("entry not held off one cycle");
	a_vec_place: assert property ($rose(q.vec_fetch) |->
		q.vec_addr == VEC_BASE + ADDR_W'({q.cur, 2'b00}) && q.maskp[q.cur] && q.pipe_abort)
		else $error("vector address or pointer wrong");
	a_global_gate: assert property (go && !sib_pkg::NON_MASKABLE[sel] |->
		q.mode[sib_pkg::MODE_IRQEN_BIT])
		else $error("entry while globally disabled");
	a_status_save: assert property (go |=> (sib_pkg::STATUS_PUSH[$past(sel)] ?
		(st_top == $past({q.mode, q.astx, q.asty})) : $stable(st_top)))
		else $error("status push for wrong source");
	a_latch_clear: assert property (q.st == sib_pkg::S_BRANCH |-> !q.latch[q.cur])
		else $error("active latch bit not cleared");
	a_rti_resume: assert property (pc_pop |=> resume_fetch && resume_addr == $past(pc_top))
		else $error("return address not resumed");
	a_no_mask: assert property ((q.mask & sib_pkg::NON_MASKABLE) == '0)
		else $error("reset or emulator masked");
	a_pin_latch: assert property ($rose(ext_irq_inputs[1]) && q.edge_sel[1] ##1 1'b1
		|-> ##[1:2] (q.latch[sib_pkg::IRQ_EXT_TOP - 1] || q.maskp[sib_pkg::IRQ_EXT_TOP - 1]))
		else $error("pin request not latched in time");
endmodule : sib_branch

// >>> sib_irq_src.sv
`timescale 1ns/1ns
module sib_irq_src (
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] fire,
	input wire logic [2:0] ack,
	output logic [2:0] ext_irq_inputs
);
	// ----------------------------------------
	// external request pins
	// ----------------------------------------
	// a request stays up until the handler acknowledges it, so a slow synchronizer never misses it
	// hold until acknowledged
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ext_irq_inputs <= 3'h0;
		else
			ext_irq_inputs <= (ext_irq_inputs | fire) & ~ack;
	end
endmodule : sib_irq_src

// >>> test_sib_branch.sv
`timescale 1ns/1ns
module test_sib_branch;
	localparam logic [23:0] VBASE = 24'h000100;
	logic clk, rst, psel, penable, pwrite, pready, pslverr;
	logic core_run, db_slot, pm_stall, rti_exec;
	logic vec_fetch, pipe_abort, resume_fetch;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [2:0] pins, fire, ack;
	logic [1:0] boot_config_pins;
	logic [41:0] int_irq_req;
	logic [23:0] cur_pc, db_target, next_pc, vec_addr, resume_addr;
	int n_mismatch, compares, cyc;

	sib_irq_src src (.clk(clk), .rst(rst), .fire(fire), .ack(ack), .ext_irq_inputs(pins));
	sib_branch #(.VEC_BASE(VBASE)) uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_irq_inputs(pins), .boot_config_pins(boot_config_pins),
		.int_irq_req(int_irq_req), .core_run(core_run), .db_slot(db_slot), .pm_stall(pm_stall),
		.rti_exec(rti_exec), .cur_pc(cur_pc), .db_target(db_target), .next_pc(next_pc),
		.vec_fetch(vec_fetch), .vec_addr(vec_addr), .pipe_abort(pipe_abort),
		.resume_fetch(resume_fetch), .resume_addr(resume_addr));

	// ----------------------------------------
	// common tasks
	// ----------------------------------------
	task automatic wrap_up;
		if (n_mismatch == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : wrap_up

	task automatic check(input logic [41:0] seen, input logic [41:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// one idle edge first, so psel is never assigned twice in one step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		check(42'(q), 42'(exp));
		check(42'(e), 42'h0);
	endtask : rd

	task automatic kick(input logic [41:0] v);
		@(posedge clk);
		int_irq_req <= v;
		@(posedge clk);
		int_irq_req <= '0;
	endtask : kick

	task automatic quiet(input int cycles);
		logic bad;
		bad = 1'b0;
		repeat (cycles)
		begin
			@(posedge clk);
			if (vec_fetch !== 1'b0)
				bad = 1'b1;
		end
		check(42'(bad), 42'h0);
	endtask : quiet

	task automatic enter(input int idx);
		int n;
		n = 0;
		while (vec_fetch !== 1'b1 && n < 60)
		begin
			@(posedge clk);
			n++;
		end
		check(42'(vec_addr), 42'(VBASE + idx * 4));
		check(42'(pipe_abort), 42'h1);
		n = 0;
		while (vec_fetch === 1'b1 && n < 9)
		begin
			@(posedge clk);
			n++;
		end
		check(42'(n), 42'h4);
	endtask : enter

	task automatic leave(input logic [23:0] ret);
		repeat (2) @(posedge clk);
		rti_exec <= 1'b1;
		@(posedge clk);
		rti_exec <= 1'b0;
		@(posedge clk);
		check(42'(resume_fetch), 42'h1);
		check(42'(resume_addr), 42'(ret));
	endtask : leave

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic s_reset;
		logic [31:0] q;
		logic e;
		rd(sib_pkg::REG_MODE, 32'h0);
		rd(sib_pkg::REG_MASK, sib_pkg::MASK_RESET[31:0] & ~(32'h1 << (sib_pkg::IRQ_BOOT_BASE + 1)));
		rd(sib_pkg::REG_MASK_EXT, 32'(sib_pkg::MASK_RESET[41:32]));
		rd(sib_pkg::REG_LATCH, 32'h0);
		apb(1'b0, 8'h40, 32'h0, q, e);
		check(42'(q), 42'h0);
		check(42'(e), 42'h1);
	endtask : s_reset

	task automatic s_pin;
		int k;
		wr(sib_pkg::REG_MODE, 32'h1 << sib_pkg::MODE_IRQEN_BIT);
		wr(sib_pkg::REG_MASK, 32'hFFDFFEFC);
		wr(sib_pkg::REG_EDGE, 32'h0);
		@(posedge clk);
		fire <= 3'h4;
		@(posedge clk);
		fire <= 3'h0;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (vec_fetch !== 1'b1 && k < 30);
		check(42'(k), 42'h5);
		enter(8);
		rd(sib_pkg::REG_LATCH, 32'h0);
		rd(sib_pkg::REG_MASKP, 32'h100);
		wr(sib_pkg::REG_MODE, 32'h1800);
		wr(sib_pkg::REG_ARITH_STATUS_X, 32'h5A5A);
		ack <= 3'h4;
		@(posedge clk);
		ack <= 3'h0;
		repeat (6) @(posedge clk);
		leave(cur_pc);
		rd(sib_pkg::REG_MASKP, 32'h0);
		rd(sib_pkg::REG_MODE, 32'h1000);
		rd(sib_pkg::REG_ARITH_STATUS_X, 32'h0);
	endtask : s_pin

	// held pin in edge mode must not come back after the handler returns
	task automatic s_edge;
		wr(sib_pkg::REG_MASK, 32'hFFDFFCFC);
		wr(sib_pkg::REG_EDGE, 32'h2);
		@(posedge clk);
		fire <= 3'h2;
		@(posedge clk);
		fire <= 3'h0;
		enter(9);
		leave(cur_pc);
		quiet(15);
		ack <= 3'h2;
		@(posedge clk);
		ack <= 3'h0;
	endtask : s_edge

	task automatic s_masked;
		kick(42'h20);
		quiet(20);
		rd(sib_pkg::REG_LATCH, 32'h20);
		wr(sib_pkg::REG_MODE, 32'h0);
		wr(sib_pkg::REG_MASK, 32'hFFDFFC1C);
		quiet(20);
		wr(sib_pkg::REG_MODE, 32'h1 << sib_pkg::MODE_IRQEN_BIT);
		enter(5);
		leave(cur_pc);
	endtask : s_masked

	task automatic s_prio;
		kick(42'hC0);
		enter(6);
		leave(cur_pc);
		enter(7);
		leave(cur_pc);
	endtask : s_prio

	task automatic s_ret;
		db_slot <= 1'b1;
		kick(42'h40);
		quiet(10);
		db_slot <= 1'b0;
		enter(6);
		leave(db_target);
		pm_stall <= 1'b1;
		kick(42'h80);
		enter(7);
		pm_stall <= 1'b0;
		leave(next_pc);
	endtask : s_ret

	// ----------------------------------------
	// clock, timeout and main sequence
	// ----------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			n_mismatch++;
			wrap_up();
		end
	end

	initial
	begin
		n_mismatch = 0;
		compares = 0;
		cyc = 0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		fire = 3'h0;
		ack = 3'h0;
		boot_config_pins = 2'h1;
		int_irq_req = '0;
		core_run = 1'b1;
		db_slot = 1'b0;
		pm_stall = 1'b0;
		rti_exec = 1'b0;
		cur_pc = 24'h000ABC;
		db_target = 24'h000DB0;
		next_pc = 24'h000ABD;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		s_reset();
		s_pin();
		s_edge();
		s_masked();
		s_prio();
		s_ret();
		wrap_up();
	end
endmodule : test_sib_branch
